// ### design/rtu_ssp_regs.svh
// Register offsets, field positions, reset values and timing figures of the RTU serial port.
// Assumes a 12-bit APB byte address and 32-bit data words.
`ifndef RTU_SSP_REGS_SVH
`define RTU_SSP_REGS_SVH
// Register byte offsets
`define RTU_OFF_CTRL 12'h000
`define RTU_OFF_ADDR 12'h004
`define RTU_OFF_LOCK 12'h008
`define RTU_OFF_STAT 12'h00c
`define RTU_OFF_MASK 12'h010
`define RTU_OFF_RXB  12'h014
`define RTU_OFF_CMD  12'h018
// Frame control, lock, command and receive byte fields
`define RTU_CTRL_RATE  3:0
`define RTU_CTRL_PAR   5:4
`define RTU_CTRL_STOP2 6
`define RTU_CTRL_DATA7 7
`define RTU_LOCK_ALL   0
`define RTU_LOCK_TOT   1
`define RTU_CMD_DEF    0
`define RTU_RXB_INMSG  8
// Status and mask bits
`define RTU_ST_OK    0
`define RTU_ST_DROP  1
`define RTU_ST_PERR  2
`define RTU_ST_SERR  3
`define RTU_ST_GAP   4
`define RTU_ST_FMT   5
`define RTU_ST_WREJ  6
`define RTU_ST_RREF  7
`define RTU_ST_W     8
// Reset and default values
`define RTU_RATE_DEF   4'h9
`define RTU_STOP2_DEF  1'h0
`define RTU_ADDR_MIN   8'h01
`define RTU_ADDR_MAX   8'hf7
`define RTU_ADDR_BCAST 8'h00
// Character shape
`define RTU_MIN_BITS   4'ha
`define RTU_STD_BITS   4'hb
`define RTU_LAST_BIT   3'h7
// Silent intervals in half characters
`define RTU_T35_HALF   32'h0000_0007
`define RTU_T15_HALF   32'h0000_0003
`define RTU_T_DEN      32'h0000_0002
// Clock and bit rates
`define RTU_CLK_HZ     100000000
`define RTU_BAUD_300   300
`define RTU_BAUD_600   600
`define RTU_BAUD_1200  1200
`define RTU_BAUD_2400  2400
`define RTU_BAUD_3600  3600
`define RTU_BAUD_4800  4800
`define RTU_BAUD_7200  7200
`define RTU_BAUD_9600  9600
`define RTU_RATE_FOURTEEN_THOUSAND_FOUR 14400
`define RTU_BAUD_19200  19200
`define RTU_BAUD_28800  28800
`define RTU_BAUD_38400  38400
`define RTU_BAUD_57600  57600
`define RTU_BAUD_76800  76800
`define RTU_BAUD_115200 115200
`define RTU_RATE_TWO_THIRTY_THOUSAND_FOUR 230400
`endif

// ### design/rtu_pkg.sv
// Types shared by the RTU serial slave port.
// Assumes nothing beyond a SystemVerilog compiler.
package rtu_pkg;
	typedef enum logic [1:0] {
		PAR_NONE = 2'b00,
		PAR_EVEN = 2'b01,
		PAR_ODD  = 2'b10,
		PAR_RSVD = 2'b11
	} rtu_par_e;
	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_PAR   = 3'b011,
		RX_STOP  = 3'b100
	} rtu_rx_e;
	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_DATA  = 3'b010,
		TX_PAR   = 3'b011,
		TX_STOP  = 3'b100
	} rtu_tx_e;
endpackage : rtu_pkg

// ### design/rtu_serial_slave_port.sv
// Serial slave port: RTU character receiver and transmitter, message framing,
// address filter, frame configuration, remote write locks, APB registers.
// Assumes rx is already synchronous to pclk and an external transceiver uses tx_en.
//
// Notes on behaviour
// - Binary RTU mode only; no ASCII mode can be selected.
// - Standard character: start, 8 data, parity plus one stop, or two stops.
// - Ten-bit characters are accepted but raise a format warning.
// - Sixteen bit rates, 300 to 230400, each with any parity and stop choice.
// - Defaults are 19200 bit/s, even parity, one stop bit.
// - A 7-bit width request is rejected, beeps and restores the default rate.
// - Slave address stays within 1 to 247; only own address is served.
// - Local configuration wins over remote configuration writes.
// - Lock-all refuses every remote write; totals lock refuses only totals.
// - Messages to broadcast address zero are ignored.
// - Multi-word values arrive most significant word first, 16 bits each.
//
// The register offsets and the APB slave port were chosen for this implementation.
`include "rtu_ssp_regs.svh"

module rtu_serial_slave_port #(
	parameter int unsigned CLK_HZ   = `RTU_CLK_HZ,
	parameter logic [7:0]  ADDR_RST = `RTU_ADDR_MIN
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial line
	input  wire logic        rx,
	output logic             tx,
	output logic             tx_en,
	// Received message stream
	output logic      [7:0]  rx_byte,
	output logic             rx_byte_valid,
	output logic             msg_ok,
	output logic             msg_drop,
	// Reply bytes
	input  wire logic        tx_valid,
	input  wire logic [7:0]  tx_byte,
	output logic             tx_ready,
	// Remote write requests
	input  wire logic        local_mode,
	input  wire logic        rem_wr_req,
	input  wire logic        rem_wr_total,
	input  wire logic        rem_wr_lsw,
	input  wire logic [15:0] rem_wr_word,
	output logic             rem_wr_grant,
	output logic             rem_wr_refuse,
	output logic             total_load,
	output logic      [31:0] total_value,
	// Operator alerts
	output logic             beep,
	output logic             fmt_warn,
	output logic             irq
);

	// ****************************************
	// Bit timing
	// ****************************************
	function automatic logic [23:0] bit_cycles(input logic [3:0] sel);
		unique case (sel)
			4'h0: return 24'(CLK_HZ / `RTU_BAUD_300);
			4'h1: return 24'(CLK_HZ / `RTU_BAUD_600);
			4'h2: return 24'(CLK_HZ / `RTU_BAUD_1200);
			4'h3: return 24'(CLK_HZ / `RTU_BAUD_2400);
			4'h4: return 24'(CLK_HZ / `RTU_BAUD_3600);
			4'h5: return 24'(CLK_HZ / `RTU_BAUD_4800);
			4'h6: return 24'(CLK_HZ / `RTU_BAUD_7200);
			4'h7: return 24'(CLK_HZ / `RTU_BAUD_9600);
			4'h8: return 24'(CLK_HZ / `RTU_RATE_FOURTEEN_THOUSAND_FOUR);
			4'h9: return 24'(CLK_HZ / `RTU_BAUD_19200);
			4'ha: return 24'(CLK_HZ / `RTU_BAUD_28800);
			4'hb: return 24'(CLK_HZ / `RTU_BAUD_38400);
			4'hc: return 24'(CLK_HZ / `RTU_BAUD_57600);
			4'hd: return 24'(CLK_HZ / `RTU_BAUD_76800);
			4'he: return 24'(CLK_HZ / `RTU_BAUD_115200);
			4'hf: return 24'(CLK_HZ / `RTU_RATE_TWO_THIRTY_THOUSAND_FOUR);
		endcase
	endfunction : bit_cycles

	function automatic logic mapped(input logic [11:0] a);
		return a == `RTU_OFF_CTRL || a == `RTU_OFF_ADDR || a == `RTU_OFF_LOCK ||
			a == `RTU_OFF_STAT || a == `RTU_OFF_MASK || a == `RTU_OFF_RXB ||
			a == `RTU_OFF_CMD;
	endfunction : mapped

	logic [3:0]            rate_q;
	rtu_pkg::rtu_par_e     par_q;
	logic                  stop2_q;
	logic [7:0]            addr_q;
	logic                  lock_all_q;
	logic                  lock_tot_q;
	logic [`RTU_ST_W-1:0]  mask_q;
	logic [`RTU_ST_W-1:0]  stat_q;
	logic [`RTU_ST_W-1:0]  ev;
	logic [31:0]           prdata_q;
	logic [31:0]           rd_mux;
	logic [23:0]           bit_cyc;
	logic [23:0]           bit_rld;
	logic [3:0]            nbits;
	logic [31:0]           t35;
	logic [31:0]           t15;

	assign bit_cyc = bit_cycles(rate_q);
	assign bit_rld = bit_cyc - 24'h00_0001;
	assign nbits   = `RTU_MIN_BITS + 4'(par_q != rtu_pkg::PAR_NONE) + 4'(stop2_q);
	assign t35     = (32'(nbits) * 32'(bit_cyc) * `RTU_T35_HALF) / `RTU_T_DEN;
	assign t15     = (32'(nbits) * 32'(bit_cyc) * `RTU_T15_HALF) / `RTU_T_DEN;

	// ****************************************
	// APB decode
	// ****************************************
	logic        acc;
	logic        wr;
	logic        loc_cfg_wr;
	logic        rd_clr;
	logic        rem_allowed;
	logic        rem_cfg_ok;
	logic        rem_tot_ok;
	logic        cfg_take;
	logic [15:0] cfg_src;
	logic        width_rej;

	assign acc        = psel & penable;
	assign wr         = acc & pwrite & mapped(paddr);
	assign pready     = 1'h1;
	assign pslverr    = acc & ~mapped(paddr);
	assign prdata     = prdata_q;
	assign loc_cfg_wr = wr && paddr == `RTU_OFF_CTRL;
	assign rd_clr     = acc && !pwrite && paddr == `RTU_OFF_STAT;

	// Remote writes lose to local mode; remote configuration writes also lose to a local write in the same cycle
	assign rem_allowed = ~local_mode & ~lock_all_q & ~(rem_wr_total & lock_tot_q);
	assign rem_cfg_ok  = rem_wr_req & ~rem_wr_total & rem_allowed & ~loc_cfg_wr;
	assign rem_tot_ok  = rem_wr_req & rem_wr_total & rem_allowed;
	assign cfg_take    = loc_cfg_wr | rem_cfg_ok;
	assign cfg_src     = loc_cfg_wr ? pwdata[15:0] : rem_wr_word;
	assign width_rej   = cfg_take & cfg_src[`RTU_CTRL_DATA7];

	// ****************************************
	// Frame configuration
	// ****************************************
	logic cfg_upd_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_q    <= `RTU_RATE_DEF;
			par_q     <= rtu_pkg::PAR_EVEN;
			stop2_q   <= `RTU_STOP2_DEF;
			cfg_upd_q <= 1'h0;
		end else begin
			cfg_upd_q <= cfg_take;
			if (wr && paddr == `RTU_OFF_CMD && pwdata[`RTU_CMD_DEF]) begin
				rate_q  <= `RTU_RATE_DEF;
				par_q   <= rtu_pkg::PAR_EVEN;
				stop2_q <= `RTU_STOP2_DEF;
			end else if (cfg_take) begin
				// Eight data bits are fixed: a 7-bit request restores the default rate but still sets parity and stops
				rate_q  <= width_rej ? `RTU_RATE_DEF : cfg_src[`RTU_CTRL_RATE];
				stop2_q <= cfg_src[`RTU_CTRL_STOP2];
				if (cfg_src[`RTU_CTRL_PAR] != rtu_pkg::PAR_RSVD) begin
					par_q <= rtu_pkg::rtu_par_e'(cfg_src[`RTU_CTRL_PAR]);
				end
			end
		end
	end

	assign fmt_warn = nbits != `RTU_STD_BITS;

	// ****************************************
	// Address, locks, mask
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_q     <= ADDR_RST;
			lock_all_q <= 1'h0;
			lock_tot_q <= 1'h0;
			mask_q     <= '0;
		end else begin
			if (wr && paddr == `RTU_OFF_ADDR && pwdata[7:0] >= `RTU_ADDR_MIN &&
					pwdata[7:0] <= `RTU_ADDR_MAX) begin
				addr_q <= pwdata[7:0];
			end
			if (wr && paddr == `RTU_OFF_LOCK) begin
				lock_all_q <= pwdata[`RTU_LOCK_ALL];
				lock_tot_q <= pwdata[`RTU_LOCK_TOT];
			end
			if (wr && paddr == `RTU_OFF_MASK) begin
				mask_q <= pwdata[`RTU_ST_W-1:0];
			end
		end
	end

	// ****************************************
	// Remote write answers and totals
	// ****************************************
	logic [15:0] tot_hi_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rem_wr_grant  <= 1'h0;
			rem_wr_refuse <= 1'h0;
			total_load    <= 1'h0;
			total_value   <= 32'h0000_0000;
			tot_hi_q      <= 16'h0000;
			beep          <= 1'h0;
		end else begin
			rem_wr_grant  <= rem_cfg_ok | rem_tot_ok;
			rem_wr_refuse <= rem_wr_req & ~(rem_cfg_ok | rem_tot_ok);
			total_load    <= rem_tot_ok & rem_wr_lsw;
			beep          <= width_rej;
			if (rem_tot_ok && !rem_wr_lsw) begin
				tot_hi_q <= rem_wr_word;
			end
			if (rem_tot_ok && rem_wr_lsw) begin
				total_value <= {tot_hi_q, rem_wr_word};
			end
		end
	end

	// ****************************************
	// Character receiver
	// ****************************************
	rtu_pkg::rtu_rx_e rx_st_q;
	logic [23:0]      rx_cnt_q;
	logic [2:0]       rx_bit_q;
	logic [7:0]       rx_shf_q;
	logic             rx_sec_q;
	logic             ch_done_q;
	logic [7:0]       ch_byte_q;
	logic             ch_perr_q;
	logic             ch_serr_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_q   <= rtu_pkg::RX_IDLE;
			rx_cnt_q  <= 24'h00_0000;
			rx_bit_q  <= 3'h0;
			rx_shf_q  <= 8'h00;
			rx_sec_q  <= 1'h0;
			ch_done_q <= 1'h0;
			ch_byte_q <= 8'h00;
			ch_perr_q <= 1'h0;
			ch_serr_q <= 1'h0;
		end else begin
			ch_done_q <= 1'h0;
			if (rx_st_q != rtu_pkg::RX_IDLE && rx_cnt_q != 24'h00_0000) begin
				rx_cnt_q <= rx_cnt_q - 24'h00_0001;
			end else begin
				rx_cnt_q <= bit_rld;
				unique case (rx_st_q)
					rtu_pkg::RX_IDLE: begin
						if (!rx) begin
							rx_st_q   <= rtu_pkg::RX_START;
							rx_cnt_q  <= bit_cyc >> 1;
							ch_perr_q <= 1'h0;
							ch_serr_q <= 1'h0;
							rx_sec_q  <= 1'h0;
						end
					end
					rtu_pkg::RX_START: begin
						// A start bit gone high at mid-bit was a glitch
						rx_st_q  <= rx ? rtu_pkg::RX_IDLE : rtu_pkg::RX_DATA;
						rx_bit_q <= 3'h0;
					end
					rtu_pkg::RX_DATA: begin
						rx_shf_q <= {rx, rx_shf_q[7:1]};
						rx_bit_q <= rx_bit_q + 3'h1;
						if (rx_bit_q == `RTU_LAST_BIT) begin
							rx_st_q <= (par_q == rtu_pkg::PAR_NONE) ?
								rtu_pkg::RX_STOP : rtu_pkg::RX_PAR;
						end
					end
					rtu_pkg::RX_PAR: begin
						ch_perr_q <= (^rx_shf_q ^ rx) ^ (par_q == rtu_pkg::PAR_ODD);
						rx_st_q   <= rtu_pkg::RX_STOP;
					end
					rtu_pkg::RX_STOP: begin
						ch_serr_q <= ch_serr_q | ~rx;
						if (stop2_q && !rx_sec_q) begin
							rx_sec_q <= 1'h1;
						end else begin
							rx_st_q   <= rtu_pkg::RX_IDLE;
							ch_done_q <= 1'h1;
							ch_byte_q <= rx_shf_q;
						end
					end
					default: rx_st_q <= rtu_pkg::RX_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// Message framing and address filter
	// ****************************************
	logic [31:0] idle_q;
	logic        in_msg_q;
	logic        ours_q;
	logic        bad_q;
	logic        ch_err;
	logic        first_ours;
	logic        gap_ev;
	logic        end_ev;

	assign ch_err     = ch_perr_q | ch_serr_q;
	assign first_ours = ch_byte_q == addr_q && ch_byte_q != `RTU_ADDR_BCAST;
	assign gap_ev     = in_msg_q && !ch_done_q && rx_st_q == rtu_pkg::RX_IDLE && !rx &&
		idle_q > t15 && idle_q < t35;
	assign end_ev     = in_msg_q && !ch_done_q && rx_st_q == rtu_pkg::RX_IDLE &&
		idle_q >= t35;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_q <= 32'h0000_0000;
		end else if (ch_done_q) begin
			idle_q <= 32'h0000_0000;
		end else if (rx_st_q == rtu_pkg::RX_IDLE && idle_q < t35) begin
			idle_q <= idle_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_msg_q      <= 1'h0;
			ours_q        <= 1'h0;
			bad_q         <= 1'h0;
			rx_byte       <= 8'h00;
			rx_byte_valid <= 1'h0;
			msg_ok        <= 1'h0;
			msg_drop      <= 1'h0;
		end else begin
			rx_byte_valid <= ch_done_q & (in_msg_q ? ours_q : first_ours);
			msg_ok        <= end_ev & ours_q & ~bad_q;
			msg_drop      <= end_ev & ours_q & bad_q;
			if (ch_done_q) begin
				rx_byte <= ch_byte_q;
				if (!in_msg_q) begin
					in_msg_q <= 1'h1;
					ours_q   <= first_ours;
					bad_q    <= ch_err;
				end else begin
					bad_q <= bad_q | ch_err;
				end
			end else if (gap_ev) begin
				bad_q <= 1'h1;
			end else if (end_ev) begin
				in_msg_q <= 1'h0;
			end
		end
	end

	// ****************************************
	// Character transmitter
	// ****************************************
	rtu_pkg::rtu_tx_e tx_st_q;
	logic [23:0]      tx_cnt_q;
	logic [2:0]       tx_bit_q;
	logic [7:0]       tx_shf_q;
	logic             tx_par_q;
	logic             tx_sec_q;

	// Inter-message silence is left to whoever feeds the reply bytes
	assign tx_ready = tx_st_q == rtu_pkg::TX_IDLE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st_q  <= rtu_pkg::TX_IDLE;
			tx_cnt_q <= 24'h00_0000;
			tx_bit_q <= 3'h0;
			tx_shf_q <= 8'h00;
			tx_par_q <= 1'h0;
			tx_sec_q <= 1'h0;
			tx       <= 1'h1;
			tx_en    <= 1'h0;
		end else if (tx_st_q != rtu_pkg::TX_IDLE && tx_cnt_q != 24'h00_0000) begin
			tx_cnt_q <= tx_cnt_q - 24'h00_0001;
		end else begin
			tx_cnt_q <= bit_rld;
			unique case (tx_st_q)
				rtu_pkg::TX_IDLE: begin
					if (tx_valid) begin
						tx_st_q  <= rtu_pkg::TX_START;
						tx_shf_q <= tx_byte;
						tx_par_q <= ^tx_byte ^ (par_q == rtu_pkg::PAR_ODD);
						tx_sec_q <= 1'h0;
						tx       <= 1'h0;
						tx_en    <= 1'h1;
					end
				end
				rtu_pkg::TX_START: begin
					tx       <= tx_shf_q[0];
					tx_shf_q <= tx_shf_q >> 1;
					tx_bit_q <= 3'h0;
					tx_st_q  <= rtu_pkg::TX_DATA;
				end
				rtu_pkg::TX_DATA: begin
					tx_bit_q <= tx_bit_q + 3'h1;
					tx_shf_q <= tx_shf_q >> 1;
					if (tx_bit_q == `RTU_LAST_BIT) begin
						tx      <= (par_q == rtu_pkg::PAR_NONE) ? 1'h1 : tx_par_q;
						tx_st_q <= (par_q == rtu_pkg::PAR_NONE) ?
							rtu_pkg::TX_STOP : rtu_pkg::TX_PAR;
					end else begin
						tx <= tx_shf_q[0];
					end
				end
				rtu_pkg::TX_PAR: begin
					tx      <= 1'h1;
					tx_st_q <= rtu_pkg::TX_STOP;
				end
				rtu_pkg::TX_STOP: begin
					if (stop2_q && !tx_sec_q) begin
						tx_sec_q <= 1'h1;
					end else begin
						tx_st_q <= rtu_pkg::TX_IDLE;
						tx_en   <= 1'h0;
					end
				end
				default: tx_st_q <= rtu_pkg::TX_IDLE;
			endcase
		end
	end

	// ****************************************
	// Status, interrupt, read data
	// ****************************************
	always_comb begin
		ev                = '0;
		ev[`RTU_ST_OK]    = msg_ok;
		ev[`RTU_ST_DROP]  = msg_drop;
		ev[`RTU_ST_PERR]  = ch_done_q & ch_perr_q;
		ev[`RTU_ST_SERR]  = ch_done_q & ch_serr_q;
		ev[`RTU_ST_GAP]   = gap_ev;
		ev[`RTU_ST_FMT]   = cfg_upd_q & fmt_warn;
		ev[`RTU_ST_WREJ]  = beep;
		ev[`RTU_ST_RREF]  = rem_wr_refuse;
	end

	// Only bits already latched into read data are cleared, so a new event survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= '0;
		end else begin
			stat_q <= (stat_q & ~(rd_clr ? prdata_q[`RTU_ST_W-1:0] : '0)) | ev;
		end
	end

	assign irq = |(stat_q & mask_q);

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			`RTU_OFF_CTRL: rd_mux = 32'({stop2_q, par_q, rate_q});
			`RTU_OFF_ADDR: rd_mux = 32'(addr_q);
			`RTU_OFF_LOCK: rd_mux = 32'({lock_tot_q, lock_all_q});
			`RTU_OFF_STAT: rd_mux = 32'(stat_q);
			`RTU_OFF_MASK: rd_mux = 32'(mask_q);
			`RTU_OFF_RXB:  rd_mux = 32'({in_msg_q, rx_byte});
			default:       rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata_q <= rd_mux;
		end
	end

endmodule : rtu_serial_slave_port

// ### testbench/rtu_ssp_assertions.sv
// Port-level checks of the RTU serial slave port.
// Assumes one pclk domain, presetn active low.
module rtu_ssp_checker (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Serial transmit side
	input wire logic tx,
	input wire logic tx_en,
	input wire logic tx_valid,
	input wire logic tx_ready,
	// Message verdicts and alerts
	input wire logic msg_ok,
	input wire logic msg_drop,
	input wire logic fmt_warn,
	input wire logic beep,
	// Remote writes
	input wire logic local_mode,
	input wire logic rem_wr_req,
	input wire logic rem_wr_grant,
	input wire logic rem_wr_refuse,
	input wire logic total_load
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_REM_ONE_ANSWER: assert property (rem_wr_req |=> rem_wr_grant != rem_wr_refuse)
		else $error("no single answer");
	AST_LOCAL_WINS: assert property (rem_wr_req && local_mode
		|=> rem_wr_refuse && !rem_wr_grant) else $error("local mode not refused");
	AST_NO_SPURIOUS_ANSWER: assert property (rem_wr_grant || rem_wr_refuse
		|-> $past(rem_wr_req)) else $error("answer without request");
	AST_TX_IDLE_HIGH: assert property (!tx_en |-> tx)
		else $error("tx low while driver disabled");
	AST_TX_LAUNCH: assert property (tx_valid && tx_ready |=> tx_en && !tx)
		else $error("no start bit");
	AST_START_BIT_HELD: assert property ($rose(tx_en) |-> !tx [*8])
		else $error("start bit too short");
	AST_ONE_VERDICT: assert property (msg_ok |-> !msg_drop)
		else $error("two verdicts");
	AST_TOTAL_LOAD_CAUSE: assert property (total_load
		|-> rem_wr_grant || $past(rem_wr_grant)) else $error("load without grant");
	AST_DEFAULT_STD_FRAME: assert property (!$past(presetn) |-> !fmt_warn)
		else $error("default frame warned");

	COV_OK: cover property (msg_ok);
	COV_DROP: cover property (msg_drop);
	COV_REFUSE: cover property (rem_wr_refuse);
	COV_BEEP: cover property (beep);
endmodule : rtu_ssp_checker

bind rtu_serial_slave_port rtu_ssp_checker rtu_ssp_checker_i (.pclk, .presetn, .tx, .tx_en,
	.tx_valid, .tx_ready, .msg_ok, .msg_drop, .fmt_warn, .beep, .local_mode, .rem_wr_req,
	.rem_wr_grant, .rem_wr_refuse, .total_load);

// ### testbench/rtu_mb_master.sv
// Bus master model at the far end of the serial line.
// Assumes a line that idles high and BIT pclk cycles per bit.
module rtu_mb_master #(
	parameter int BIT = 10
) (
	// Clock
	input wire logic pclk,
	// Serial line
	output logic     line,
	input wire logic tx_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Character send and receive
	// ****************************************
	initial line = 1'b1;

	task automatic put(input logic v);
		line <= v;
		repeat (BIT) @(posedge pclk);
	endtask : put

	// Binary characters only, LSB first; bad flips the parity bit
	task automatic send(input logic [7:0] b, input logic [1:0] par, input logic two,
			input logic bad);
		@(posedge pclk);
		put(1'b0);
		for (int i = 0; i < 8; i++) begin
			put(b[i]);
		end
		if (par != 2'b00) begin
			put((^b) ^ par[1] ^ bad);
		end
		put(1'b1);
		if (two) begin
			put(1'b1);
		end
	endtask : send

	// Samples a reply character at bit centres
	task automatic recv(output logic [7:0] b, output logic p, output logic s);
		wait (tx_line === 1'b0);
		repeat (BIT / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge pclk);
			b[i] = tx_line;
		end
		repeat (BIT) @(posedge pclk);
		p = tx_line;
		repeat (BIT) @(posedge pclk);
		s = tx_line;
	endtask : recv
endmodule : rtu_mb_master

// ### testbench/tb.sv
// Self-checking bench of the RTU serial slave port.
// Assumes the register header; CLK_HZ shrunk to 10 cycles a bit at 230400 bit/s, 120 at the default rate.
`include "rtu_ssp_regs.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Harness
	// ****************************************
	localparam int unsigned CLK_HZ = 2304000;
	localparam int          BIT    = 10;
	localparam int          LIMIT  = 80000;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rx, tx, tx_en;
	logic        rx_byte_valid, msg_ok, msg_drop, tx_valid, tx_ready, local_mode, rem_wr_req;
	logic        rem_wr_total, rem_wr_lsw, rem_wr_grant, rem_wr_refuse, total_load, beep;
	logic        fmt_warn, irq;
	logic [7:0]  rx_byte, tx_byte, last_b;
	logic [11:0] paddr;
	logic [15:0] rem_wr_word;
	logic [31:0] pwdata, prdata, total_value;
	int          bad_count, n_checks, cyc, n_bytes, n_ok, n_drop, n_beep, n_load;

	rtu_serial_slave_port #(.CLK_HZ(CLK_HZ)) rtu_serial_slave_port_i (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx, .tx, .tx_en,
		.rx_byte, .rx_byte_valid, .msg_ok, .msg_drop, .tx_valid, .tx_byte, .tx_ready,
		.local_mode, .rem_wr_req, .rem_wr_total, .rem_wr_lsw, .rem_wr_word, .rem_wr_grant,
		.rem_wr_refuse, .total_load, .total_value, .beep, .fmt_warn, .irq);
	rtu_mb_master #(.BIT(BIT)) rtu_mb_master_i (.pclk, .line(rx), .tx_line(tx));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cyc++;
		if (rx_byte_valid === 1'b1) begin
			n_bytes++;
			last_b = rx_byte;
		end
		n_ok += (msg_ok === 1'b1);
		n_drop += (msg_drop === 1'b1);
		n_beep += (beep === 1'b1);
		n_load += (total_load === 1'b1);
		if (cyc == LIMIT) begin
			bad_count++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(what, exp, r);
	endtask : rdc

	// Waits out a 3.5 character silence
	task automatic frame(input logic [7:0] q[$], input logic [1:0] par, input logic two,
			input int bad_at);
		n_bytes = 0;
		n_ok = 0;
		n_drop = 0;
		foreach (q[i]) rtu_mb_master_i.send(q[i], par, two, i == bad_at);
		repeat (600) @(posedge pclk);
	endtask : frame

	task automatic rem(input logic t, input logic l, input logic [15:0] w, input logic exp);
		@(posedge pclk);
		rem_wr_req <= 1'b1;
		rem_wr_total <= t;
		rem_wr_lsw <= l;
		rem_wr_word <= w;
		@(posedge pclk);
		rem_wr_req <= 1'b0;
		@(posedge pclk);
		chk("grant", 32'(exp), 32'(rem_wr_grant));
		chk("refuse", 32'(!exp), 32'(rem_wr_refuse));
	endtask : rem

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		logic [31:0] r;
		logic        e;
		logic [7:0]  v[4] = '{8'h00, 8'hf8, 8'hf7, 8'h05};
		logic [7:0]  x[4] = '{8'h01, 8'h01, 8'hf7, 8'h05};
		rdc("ctrl default", `RTU_OFF_CTRL, 32'h0000_0019);
		rdc("addr default", `RTU_OFF_ADDR, 32'h0000_0001);
		wr(`RTU_OFF_CTRL, 32'h0000_0119);
		rdc("ascii bit", `RTU_OFF_CTRL, 32'h0000_0019);
		apb(1'b0, 12'h020, 32'h0000_0000, r, e);
		chk("unmapped err", 32'h0000_0001, 32'(e));
		for (int i = 0; i < 16; i++) begin
			wr(`RTU_OFF_CTRL, 32'h0000_0010 | i);
			rdc("rate", `RTU_OFF_CTRL, 32'h0000_0010 | i);
		end
		for (int i = 0; i < 4; i++) begin
			wr(`RTU_OFF_ADDR, 32'(v[i]));
			rdc("addr", `RTU_OFF_ADDR, 32'(x[i]));
		end
	endtask : t_regs

	task automatic t_seven();
		wr(`RTU_OFF_MASK, 32'h0000_0040);
		n_beep = 0;
		wr(`RTU_OFF_CTRL, 32'h0000_00ef);
		repeat (3) @(posedge pclk);
		chk("beep", 32'h0000_0001, n_beep);
		rdc("ctrl", `RTU_OFF_CTRL, 32'h0000_0069);
		wr(`RTU_OFF_CMD, 32'h0000_0001);
		rdc("ctrl restore", `RTU_OFF_CTRL, 32'h0000_0019);
		chk("irq set", 32'h0000_0001, 32'(irq));
		rdc("stat", `RTU_OFF_STAT, 32'h0000_0060);
		@(posedge pclk);
		chk("irq clear", 32'h0000_0000, 32'(irq));
		wr(`RTU_OFF_MASK, 32'h0000_0000);
	endtask : t_seven

	task automatic t_serial();
		logic [1:0] p;
		for (int k = 0; k < 6; k++) begin
			p = k % 3;
			wr(`RTU_OFF_CTRL, {25'h0, k >= 3, 2'(p), 4'hf});
			@(posedge pclk);
			chk("warn", 32'((p != 2'b00) == (k >= 3)), 32'(fmt_warn));
			frame('{8'h05, 8'h03, 8'h00, 8'h01}, p, k >= 3, -1);
			chk("bytes", 32'h0000_0004, n_bytes);
			chk("ok", 32'h0000_0001, n_ok);
			chk("last", 32'h0000_0001, 32'(last_b));
		end
		wr(`RTU_OFF_CTRL, 32'h0000_001f);
		frame('{8'h07, 8'h03}, 2'b01, 1'b0, -1);
		chk("foreign", 32'h0000_0000, n_bytes + n_ok + n_drop);
		frame('{8'h00, 8'h06}, 2'b01, 1'b0, -1);
		chk("bcast", 32'h0000_0000, n_bytes + n_ok + n_drop);
		frame('{8'h05, 8'h03}, 2'b01, 1'b0, 1);
		chk("perr drop", 32'h0000_0001, n_drop + 2 * n_ok);
		n_drop = 0;
		rtu_mb_master_i.send(8'h05, 2'b01, 1'b0, 1'b0);
		repeat (200) @(posedge pclk);
		frame('{8'h03}, 2'b01, 1'b0, -1);
		chk("gap drop", 32'h0000_0001, n_drop + 2 * n_ok);
	endtask : t_serial

	task automatic t_tx();
		logic [7:0] b;
		logic       p, s;
		@(posedge pclk);
		tx_byte <= 8'ha5;
		tx_valid <= 1'b1;
		do @(posedge pclk); while (tx_ready !== 1'b1);
		tx_valid <= 1'b0;
		rtu_mb_master_i.recv(b, p, s);
		chk("tx byte", 32'h0000_00a5, 32'(b));
		chk("tx parity", 32'(^8'ha5), 32'(p));
		chk("tx stop", 32'h0000_0001, 32'(s));
		repeat (20) @(posedge pclk);
	endtask : t_tx

	task automatic t_remote();
		for (int k = 0; k < 4; k++) begin
			wr(`RTU_OFF_LOCK, {30'h0, k == 2, k == 1});
			local_mode <= (k == 3);
			rem(1'b1, 1'b0, 16'h0000, k == 0);
			rem(1'b0, 1'b0, 16'h001f, k == 0 || k == 2);
		end
		wr(`RTU_OFF_LOCK, 32'h0000_0000);
		local_mode <= 1'b0;
		n_load = 0;
		rem(1'b1, 1'b0, 16'ha987, 1'b1);
		rem(1'b1, 1'b1, 16'h1023, 1'b1);
		@(posedge pclk);
		chk("load", 32'h0000_0001, n_load);
		chk("total", 32'ha987_1023, total_value);
	endtask : t_remote

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, tx_valid, local_mode, rem_wr_req, rem_wr_total, rem_wr_lsw} = '0;
		{paddr, pwdata, tx_byte, rem_wr_word} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_seven();
		t_serial();
		t_tx();
		t_remote();
		summarize();
	end
endmodule : tb
